// file: common/ici_map.svh
// register offsets, field positions and reset values of the interrupt clear block
// How it works
// - reading the all-clear register clears combined output, software flags and abort cause
// - all-clear leaves hardware-cleared flags such as FIFO thresholds untouched
// - abort cause clearing is blocked by the bit 9 exception
// - reading receive-underflow clear register clears raw bit 0
// - reading receive-overflow clear register clears raw bit 1
// - reading transmit-overflow clear register clears raw bit 3
// - reading read-request clear register clears raw bit 5
// - reading transmit-abort clear register clears raw bit 6 and abort cause
// - transmit-abort clear read releases the transmit FIFO from its flushed hold
// - reading receive-done clear register clears raw bit 7
// - activity clear read clears activity flag only when bus no longer active
// - while bus stays active the activity flag stays set despite the read
// - activity flag clears by itself once disabled and bus idle
// - activity clear read returns the activity flag, raw bit 8
// - reading start-detect clear register clears raw bit 10
// - reading general-call clear register clears raw bit 11
// - underflow sets when data port is read with empty receive FIFO
// - transmit overflow sets when writing with 32 entries in transmit FIFO
// - enable bit 0 disables and flushes FIFOs; takes effect three clocks after the write
`ifndef ICI_MAP_SVH
`define ICI_MAP_SVH
`define ICI_ADDR_CLR_ALL      32'h50001440
`define ICI_ADDR_RECEIVE_UNDERFLOW_CLEAR 32'h50001444
`define ICI_ADDR_RECEIVE_OVERFLOW_CLEAR  32'h50001448
`define ICI_ADDR_TRANSMIT_OVERFLOW_CLEAR  32'h5000144c
`define ICI_ADDR_READ_REQUEST_CLEAR   32'h50001450
`define ICI_ADDR_CLR_TX_ABORT 32'h50001454
`define ICI_ADDR_RECEIVE_DONE_CLEAR  32'h50001458
`define ICI_ADDR_BUS_ACTIVITY_CLEAR 32'h5000145c
`define ICI_ADDR_CLR_STOP     32'h50001460
`define ICI_ADDR_CLR_START    32'h50001464
`define ICI_ADDR_GENERAL_CALL_CLEAR 32'h50001468
`define ICI_ADDR_ENABLE       32'h5000146c
`define ICI_ADDR_RAW_STATUS   32'h50001434
`define ICI_ADDR_ABORT_CAUSE  32'h50001480
`define ICI_BIT_RX_UNDER      0
`define ICI_BIT_RX_OVER       1
`define ICI_BIT_RX_FULL       2
`define ICI_BIT_TX_OVER       3
`define ICI_BIT_TX_EMPTY      4
`define ICI_BIT_RD_REQ        5
`define ICI_BIT_TX_ABORT      6
`define ICI_BIT_RX_DONE       7
`define ICI_BIT_ACTIVITY      8
`define ICI_BIT_STOP          9
`define ICI_BIT_START         10
`define ICI_BIT_GENERAL_CALL_FLAG      11
`define ICI_CAUSE_HOLD_BIT    9
`define ICI_SW_FLAG_MASK      16'h0feb
`define ICI_RAW_RESET         16'h0000
`define ICI_CAUSE_RESET       16'h0000
`define ICI_FIFO_DEPTH        32
`define ICI_ENABLE_DELAY      2
`endif

// file: common/ici_pkg.sv
// types of the interrupt clear block
package ici_pkg;
  typedef struct packed {
    logic [15:0] raw;
    logic [15:0] cause;
    logic [1:0]  en_pipe;
    logic        enabled;
    logic        enable_req;
    logic        flush;
    logic        tx_hold;
    logic        combined;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } ici_state_type;
endpackage

// file: rtl/ici_irq_clear.sv
// read-to-clear interrupt flags, abort cause and controller enable behind APB
`timescale 1ns/1ps
`include "ici_map.svh"
module ici_irq_clear
  import ici_pkg::*;
#(
  parameter int FIFO_DEPTH = `ICI_FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_active,
  input  wire logic        restart_enabled,
  input  wire logic        data_port_read,
  input  wire logic        data_port_write,
  input  wire logic [5:0]  rx_fifo_level,
  input  wire logic [5:0]  tx_fifo_level,
  input  wire logic        rx_full_level,
  input  wire logic        tx_empty_level,
  input  wire logic        rx_overflow_event,
  input  wire logic        read_request_event,
  input  wire logic        abort_event,
  input  wire logic [15:0] abort_cause_set,
  input  wire logic        rx_done_event,
  input  wire logic        stop_event,
  input  wire logic        start_event,
  input  wire logic        general_call_event,
  output logic      [15:0] raw_irq_status,
  output logic      [15:0] abort_cause_register,
  output logic             combined_irq,
  output logic             controller_enabled,
  output logic             fifo_flush,
  output logic             tx_fifo_hold
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 63) begin : g_depth_check
    $error("FIFO_DEPTH must fit the 6-bit level inputs");
  end

  localparam logic [5:0] DEPTH = 6'(FIFO_DEPTH);

  ici_state_type state_reg;
  ici_state_type state_next;

  logic        setup;
  logic        access_done;
  logic        rd_done;
  logic        wr_done;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic        cause_clear;
  logic        idle_disabled;
  logic        mapped;
  logic [15:0] read_value;

  always_comb begin
    setup       = psel && !penable;
    access_done = psel && penable && state_reg.ready;
    rd_done     = access_done && !pwrite;
    wr_done     = access_done && pwrite;
    idle_disabled = !state_reg.enabled && !bus_active;

    // hardware set sources
    set_bits = 16'h0000;
    set_bits[`ICI_BIT_RX_UNDER] = data_port_read && (rx_fifo_level == 6'h00);
    set_bits[`ICI_BIT_RX_OVER]  = rx_overflow_event;
    set_bits[`ICI_BIT_TX_OVER]  = data_port_write && (tx_fifo_level >= DEPTH);
    set_bits[`ICI_BIT_RD_REQ]   = read_request_event;
    set_bits[`ICI_BIT_TX_ABORT] = abort_event;
    set_bits[`ICI_BIT_RX_DONE]  = rx_done_event;
    set_bits[`ICI_BIT_ACTIVITY] = bus_active;
    set_bits[`ICI_BIT_STOP]     = stop_event;
    set_bits[`ICI_BIT_START]    = start_event;
    set_bits[`ICI_BIT_GENERAL_CALL_FLAG] = general_call_event;

    // software clears come from reads only; writes never clear
    clr_bits    = 16'h0000;
    cause_clear = 1'b0;
    if (rd_done) begin
      unique case (paddr)
        `ICI_ADDR_CLR_ALL: begin
          clr_bits    = `ICI_SW_FLAG_MASK;
          clr_bits[`ICI_BIT_ACTIVITY] = !bus_active;
          cause_clear = 1'b1;
        end
        `ICI_ADDR_RECEIVE_UNDERFLOW_CLEAR: clr_bits[`ICI_BIT_RX_UNDER] = 1'b1;
        `ICI_ADDR_RECEIVE_OVERFLOW_CLEAR:  clr_bits[`ICI_BIT_RX_OVER]  = 1'b1;
        `ICI_ADDR_TRANSMIT_OVERFLOW_CLEAR:  clr_bits[`ICI_BIT_TX_OVER]  = 1'b1;
        `ICI_ADDR_READ_REQUEST_CLEAR:   clr_bits[`ICI_BIT_RD_REQ]   = 1'b1;
        `ICI_ADDR_CLR_TX_ABORT: begin
          clr_bits[`ICI_BIT_TX_ABORT] = 1'b1;
          cause_clear = 1'b1;
        end
        `ICI_ADDR_RECEIVE_DONE_CLEAR:  clr_bits[`ICI_BIT_RX_DONE]  = 1'b1;
        `ICI_ADDR_BUS_ACTIVITY_CLEAR: clr_bits[`ICI_BIT_ACTIVITY] = !bus_active;
        `ICI_ADDR_CLR_STOP:     clr_bits[`ICI_BIT_STOP]     = 1'b1;
        `ICI_ADDR_CLR_START:    clr_bits[`ICI_BIT_START]    = 1'b1;
        `ICI_ADDR_GENERAL_CALL_CLEAR: clr_bits[`ICI_BIT_GENERAL_CALL_FLAG] = 1'b1;
        default: ;
      endcase
    end
    // disabled and idle: sticky error flags and activity drop by themselves
    if (idle_disabled) begin
      clr_bits[`ICI_BIT_RX_UNDER] = 1'b1;
      clr_bits[`ICI_BIT_RX_OVER]  = 1'b1;
      clr_bits[`ICI_BIT_TX_OVER]  = 1'b1;
      clr_bits[`ICI_BIT_ACTIVITY] = 1'b1;
    end

    // read data is prepared in the setup cycle
    mapped = 1'b1;
    read_value = 16'h0000;
    unique case (paddr)
      `ICI_ADDR_CLR_ALL:      read_value[0] = state_reg.combined;
      `ICI_ADDR_RECEIVE_UNDERFLOW_CLEAR: read_value[0] = state_reg.raw[`ICI_BIT_RX_UNDER];
      `ICI_ADDR_RECEIVE_OVERFLOW_CLEAR:  read_value[0] = state_reg.raw[`ICI_BIT_RX_OVER];
      `ICI_ADDR_TRANSMIT_OVERFLOW_CLEAR:  read_value[0] = state_reg.raw[`ICI_BIT_TX_OVER];
      `ICI_ADDR_READ_REQUEST_CLEAR:   read_value[0] = state_reg.raw[`ICI_BIT_RD_REQ];
      `ICI_ADDR_CLR_TX_ABORT: read_value[0] = state_reg.raw[`ICI_BIT_TX_ABORT];
      `ICI_ADDR_RECEIVE_DONE_CLEAR:  read_value[0] = state_reg.raw[`ICI_BIT_RX_DONE];
      `ICI_ADDR_BUS_ACTIVITY_CLEAR: read_value[0] = state_reg.raw[`ICI_BIT_ACTIVITY];
      `ICI_ADDR_CLR_STOP:     read_value[0] = state_reg.raw[`ICI_BIT_STOP];
      `ICI_ADDR_CLR_START:    read_value[0] = state_reg.raw[`ICI_BIT_START];
      `ICI_ADDR_GENERAL_CALL_CLEAR: read_value[0] = state_reg.raw[`ICI_BIT_GENERAL_CALL_FLAG];
      `ICI_ADDR_ENABLE:       read_value[0] = state_reg.enable_req;
      `ICI_ADDR_RAW_STATUS:   read_value    = state_reg.raw;
      `ICI_ADDR_ABORT_CAUSE:  read_value    = state_reg.cause;
      default:                mapped        = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;

    // set wins over clear
    state_next.raw = (state_reg.raw & ~clr_bits) | set_bits;
    // hardware-cleared threshold flags mirror their levels, the receive-full flag only while enabled
    state_next.raw[`ICI_BIT_RX_FULL]  = rx_full_level && state_reg.enabled;
    state_next.raw[`ICI_BIT_TX_EMPTY] = tx_empty_level;
    state_next.raw[15:12] = 4'h0;

    // bit 9 of the cause blocks clearing until restarts are allowed
    state_next.cause = state_reg.cause;
    if (cause_clear && !(state_reg.cause[`ICI_CAUSE_HOLD_BIT] && !restart_enabled)) begin
      state_next.cause = 16'h0000;
    end
    state_next.cause = state_next.cause | abort_cause_set;

    // abort holds the transmit FIFO flushed until its clear read
    if (abort_event) begin
      state_next.tx_hold = 1'b1;
    end else if (rd_done && paddr == `ICI_ADDR_CLR_TX_ABORT) begin
      state_next.tx_hold = 1'b0;
    end

    if (wr_done && paddr == `ICI_ADDR_ENABLE) begin
      state_next.enable_req = pwdata[0];
    end
    // three controller clocks from enable_req to effect
    state_next.en_pipe = {state_reg.en_pipe[0], state_reg.enable_req};
    state_next.enabled = state_reg.en_pipe[1];
    state_next.flush   = !state_reg.en_pipe[1];

    state_next.combined = |(state_next.raw & `ICI_SW_FLAG_MASK);

    state_next.ready = setup;
    if (setup) begin
      state_next.rdata  = pwrite ? 32'h0000_0000 : {16'h0000, read_value};
      state_next.slverr = !mapped;
    end else if (access_done) begin
      state_next.rdata  = 32'h0000_0000;
      state_next.slverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{raw: `ICI_RAW_RESET, cause: `ICI_CAUSE_RESET, en_pipe: 2'b00,
                     enabled: 1'b0, enable_req: 1'b0, flush: 1'b1, tx_hold: 1'b0,
                     combined: 1'b0, rdata: 32'h0000_0000, ready: 1'b0, slverr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata               = state_reg.rdata;
  assign pready               = state_reg.ready;
  assign pslverr              = state_reg.slverr;
  assign raw_irq_status       = state_reg.raw;
  assign abort_cause_register = state_reg.cause;
  assign combined_irq         = state_reg.combined;
  assign controller_enabled   = state_reg.enabled;
  assign fifo_flush           = state_reg.flush;
  assign tx_fifo_hold         = state_reg.tx_hold;

endmodule // ici_irq_clear

// file: testbench/ici_irq_clear_assertions.sv
// port-level checks of the interrupt clear block
`timescale 1ns/1ps
module ici_irq_clear_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        bus_active,
  input wire logic        restart_enabled,
  input wire logic        abort_event,
  input wire logic        start_event,
  input wire logic        general_call_event,
  input wire logic [15:0] raw_irq_status,
  input wire logic [15:0] abort_cause_register,
  input wire logic        combined_irq,
  input wire logic        controller_enabled,
  input wire logic        fifo_flush,
  input wire logic        tx_fifo_hold
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && pready && !pwrite;
  wire wr = psel && penable && pready && pwrite;
  property p_start;
    rd && paddr == 32'h50001464 && !start_event |=> !raw_irq_status[10];
  endproperty
  a_start: assert property (p_start) else $error("start flag kept");
  property p_gen;
    rd && paddr == 32'h50001468 && !general_call_event |=> !raw_irq_status[11];
  endproperty
  a_gen: assert property (p_gen) else $error("general call flag kept");
  property p_act_hold;
    rd && paddr == 32'h5000145c && bus_active |=> raw_irq_status[8];
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("activity lost");
  property p_act_val;
    rd && paddr == 32'h5000145c |-> prdata == {31'h0, $past(raw_irq_status[8])};
  endproperty
  a_act_val: assert property (p_act_val) else $error("activity read");
  property p_hold9;
    rd && (paddr == 32'h50001454 || paddr == 32'h50001440) && abort_cause_register[9]
      && !restart_enabled |=> abort_cause_register[9];
  endproperty
  a_hold9: assert property (p_hold9) else $error("cause cleared");
  property p_release;
    rd && paddr == 32'h50001454 && !abort_event |=> !tx_fifo_hold;
  endproperty
  a_release: assert property (p_release) else $error("fifo still held");
  property p_enable;
    wr && paddr == 32'h5000146c |-> ##4 controller_enabled == $past(pwdata[0], 4)
      && fifo_flush != controller_enabled;
  endproperty
  a_enable: assert property (p_enable) else $error("enable not applied");
  property p_rsv;
    rd && paddr >= 32'h50001440 && paddr <= 32'h50001468 |-> prdata[31:1] == 31'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  c_all: cover property (rd && paddr == 32'h50001440 && combined_irq);
  c_abort: cover property (rd && paddr == 32'h50001454 && abort_cause_register[9]);
  c_act: cover property (rd && paddr == 32'h5000145c && bus_active);
endmodule // ici_irq_clear_assertions
bind ici_irq_clear ici_irq_clear_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .bus_active, .restart_enabled, .abort_event, .start_event,
  .general_call_event, .raw_irq_status, .abort_cause_register, .combined_irq,
  .controller_enabled, .fifo_flush, .tx_fifo_hold);

// file: testbench/tb_top.sv
// self-checking bench of the interrupt clear block
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        bus_active, restart_enabled, rx_full_level, tx_empty_level;
  logic        combined_irq, controller_enabled, fifo_flush, tx_fifo_hold;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [15:0] raw_irq_status, abort_cause_register, cs;
  logic [8:0]  ev;
  logic [5:0]  rxl, txl;
  int          error_cnt, check_count, cyc, m_raw, m_cause;
  int          fb[9] = '{0, 1, 3, 5, 6, 7, 9, 10, 11};
  ici_irq_clear u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_active, .restart_enabled, .data_port_read(ev[0]),
    .data_port_write(ev[2]), .rx_fifo_level(rxl), .tx_fifo_level(txl), .rx_full_level,
    .tx_empty_level, .rx_overflow_event(ev[1]), .read_request_event(ev[3]),
    .abort_event(ev[4]), .abort_cause_set(cs), .rx_done_event(ev[5]), .stop_event(ev[6]),
    .start_event(ev[7]), .general_call_event(ev[8]), .raw_irq_status, .abort_cause_register,
    .combined_irq, .controller_enabled, .fifo_flush, .tx_fifo_hold);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ca(input int k);
    return 32'h50001444 + 4 * (k < 6 ? k : k + 1);
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input logic [8:0] v, input logic [15:0] c);
    @(posedge pclk);
    ev <= v;
    cs <= c;
    @(posedge pclk);
    ev <= '0;
    cs <= '0;
    foreach (fb[k]) if (v[k]) m_raw |= 1 << fb[k];
    m_cause |= c;
  endtask
  task automatic look;
    int x;
    @(negedge pclk);
    x = m_raw | (rx_full_level << 2) | (tx_empty_level << 4);
    chk(raw_irq_status, x);
    chk(combined_irq, |(x & 'hfeb));
    chk(abort_cause_register, m_cause);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, cs} = '0;
    {bus_active, restart_enabled, rx_full_level, tx_empty_level} = '0;
    {rxl, txl} = {6'h00, 6'h20};
    presetn = 1'b0;
    seed = 32'hf7ac;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    look;
    apb(1'b1, 32'h5000146c, 32'h1);
    repeat (5) @(posedge pclk);
    chk({controller_enabled, fifo_flush}, 2'b10);
    $display("enable test done");
    for (int k = 0; k < 9; k++) begin
      fire(9'h1 << k, 16'h0);
      seed = lfsr(seed);
      apb(1'b1, ca(k), seed);
      look;
      apb(1'b0, ca(k), 32'h0);
      chk(rd, 32'h1);
      m_raw &= ~(1 << fb[k]);
      look;
    end
    $display("single clear test done");
    @(posedge pclk);
    rxl <= 6'h01;
    txl <= 6'h1f;
    fire(9'h005, 16'h0);
    m_raw &= ~32'h9;
    look;
    @(posedge pclk);
    rxl <= 6'h00;
    txl <= 6'h20;
    seed = lfsr(seed);
    @(posedge pclk);
    rx_full_level  <= 1'b1;
    tx_empty_level <= seed[0];
    fire(9'h010, seed[15:0] | 16'h0200);
    @(negedge pclk);
    chk(tx_fifo_hold, 1'b1);
    apb(1'b0, 32'h50001454, 32'h0);
    m_raw &= ~32'h40;
    look;
    chk(tx_fifo_hold, 1'b0);
    @(posedge pclk);
    restart_enabled <= 1'b1;
    fire(9'h1ff, seed[31:16]);
    apb(1'b0, 32'h50001440, 32'h0);
    chk(rd, 32'h1);
    m_raw = 0;
    m_cause = 0;
    look;
    $display("abort test done");
    @(posedge pclk);
    bus_active <= 1'b1;
    apb(1'b0, 32'h5000145c, 32'h0);
    chk(rd, 32'h1);
    m_raw = 'h100;
    look;
    @(posedge pclk);
    bus_active <= 1'b0;
    apb(1'b0, 32'h5000145c, 32'h0);
    m_raw = 0;
    look;
    @(posedge pclk);
    bus_active <= 1'b1;
    apb(1'b1, 32'h5000146c, 32'h0);
    repeat (5) @(posedge pclk);
    chk({controller_enabled, fifo_flush}, 2'b01);
    bus_active     <= 1'b0;
    rx_full_level  <= 1'b0;
    tx_empty_level <= 1'b0;
    repeat (2) @(posedge pclk);
    look;
    apb(1'b0, 32'h50001470, 32'h0);
    chk(rd, 32'h0);
    chk(e, 1'b1);
    $display("activity test done");
    test_done;
  end
endmodule // tb_top
